/* core/ms_delay.sv */
module ms_delay #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  // control
  input  wire logic             restart_in,
  input  wire logic             tick_in,
  input  wire logic [WIDTH-1:0] target_in,
  output logic                  done_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb
  begin
    next_count = count;
    if (restart_in)
      next_count = '0;
    else if (tick_in && count < target_in)
      next_count = count + 1'b1;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      count <= '0;
    else
      count <= next_count;
  end

  // restart clears done so a stale expiry never leaks into the new state
  assign done_out = !restart_in && (count >= target_in);
endmodule

/* core/servo_sequence.sv */
// Functional notes
// - analog speed command below dead band is treated as zero speed
// - non-negative brake delay: brake interlock drops that many ms after servo-on drops
// - negative brake delay: brake interlock drops first, servo off after magnitude ms
// - zero-speed output asserted while motor speed magnitude is below the window
// - undervoltage raises alarm and stops; restart option resumes without alarm reset
// - speed mode stop is instantaneous when y=1 or on a warning stop, decelerating otherwise
// - alarm-history clear written 1 acts at next power-up, then self-clears
// - overload warning stops motor immediately when y=1, ignored when y=0
// - after alarm clear, display stays on alarm when z=0, returns when z=1
// - serial link answers using station number 1 to 32, default 1
module servo_sequence
  import servo_seq_pkg::*;
#(
  parameter int CMD_W   = 16,
  parameter int SPEED_W = 16
) (
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       sys_rst_in,
  // parameter port from the serial link
  input  wire servo_seq_pkg::param_wr_t   param_wr_in,
  input  wire logic [2:0]                 param_rd_addr_in,
  output logic [15:0]                     param_rd_data_out,
  // drive status inputs
  input  wire servo_seq_pkg::drive_status_t status_in,
  input  wire logic signed [CMD_W-1:0]    speed_cmd_mv_in,
  input  wire logic signed [SPEED_W-1:0]  motor_speed_in,
  input  wire logic                       power_up_in,
  input  wire logic [7:0]                 link_station_in,
  // outputs
  output logic signed [CMD_W-1:0]         speed_cmd_eff_out,
  output logic                            brake_interlock_out,
  output logic                            servo_enable_out,
  output logic                            zero_speed_output_out,
  output logic                            undervolt_alarm_out,
  output logic                            stop_instant_out,
  output logic                            stop_decel_out,
  output logic                            history_clear_out,
  output logic                            show_alarm_screen_out,
  output logic                            station_match_out,
  output logic [5:0]                      station_number_out
);
  logic [15:0] dead_band;
  logic [15:0] brake_dly;
  logic [15:0] zero_window;
  logic [15:0] stop_opt;
  logic [15:0] alarm_opt;
  logic [15:0] station;
  logic [15:0] next_dead_band;
  logic [15:0] next_brake_dly;
  logic [15:0] next_zero_window;
  logic [15:0] next_stop_opt;
  logic [15:0] next_alarm_opt;
  logic [15:0] next_station;

  // parameter store; out-of-range writes are refused and keep the old value, option writes are masked to their field bits
  always_comb
  begin
    next_dead_band   = dead_band;
    next_brake_dly   = brake_dly;
    next_zero_window = zero_window;
    next_stop_opt    = stop_opt;
    next_alarm_opt   = alarm_opt;
    next_station     = station;
    if (param_wr_in.wr)
    begin
      unique case (param_wr_in.addr)
        IDX_DEAD_BAND:
          if (param_wr_in.data <= MAX_DEAD_BAND)
            next_dead_band = param_wr_in.data;
        IDX_BRAKE_DLY:
          if ($signed(param_wr_in.data) >= -$signed(MAX_BRAKE_MAG) &&
              $signed(param_wr_in.data) <= $signed(MAX_BRAKE_MAG))
            next_brake_dly = param_wr_in.data;
        IDX_ZERO_SPEED:
          if (param_wr_in.data <= MAX_ZERO_SPEED)
            next_zero_window = param_wr_in.data;
        IDX_STOP_OPT:
          next_stop_opt = param_wr_in.data & 16'h0011;
        IDX_ALARM_OPT:
          next_alarm_opt = param_wr_in.data & 16'h0111;
        IDX_STATION:
          if (param_wr_in.data >= MIN_STATION && param_wr_in.data <= MAX_STATION)
            next_station = param_wr_in.data;
        default:
          ;
      endcase
    end
    // pending history clear executes on power-up and the flag returns to 0
    // a new request written in the power-up cycle wins over the pending clear
    if (power_up_in && alarm_opt[FLD_X] &&
        !(param_wr_in.wr && param_wr_in.addr == IDX_ALARM_OPT))
      next_alarm_opt[FLD_X] = 1'b0;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      dead_band   <= RST_DEAD_BAND;
      brake_dly   <= RST_BRAKE_DLY;
      zero_window <= RST_ZERO_SPEED;
      stop_opt    <= RST_STOP_OPT;
      alarm_opt   <= RST_ALARM_OPT;
      station     <= RST_STATION;
    end
    else
    begin
      dead_band   <= next_dead_band;
      brake_dly   <= next_brake_dly;
      zero_window <= next_zero_window;
      stop_opt    <= next_stop_opt;
      alarm_opt   <= next_alarm_opt;
      station     <= next_station;
    end
  end

  // millisecond tick, free running
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic        tick;
  assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

  always_comb
  begin
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= next_tick_cnt;
  end

  // brake sequence
  logic        son_q;
  logic        son_edge;
  logic        brake_neg;
  logic [10:0] brake_mag;
  logic        dly_done;
  seq_state_t  state;
  seq_state_t  next_state;

  assign brake_neg = brake_dly[15];
  assign brake_mag = brake_neg ? 11'(-brake_dly) : brake_dly[10:0];
  assign son_edge  = status_in.servo_on ^ son_q;

  ms_delay #(
    .WIDTH (11)
  ) u_brake_delay (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .restart_in (son_edge),
    .tick_in    (tick),
    .target_in  (brake_mag),
    .done_out   (dly_done)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_OFF:
        if (status_in.servo_on)
          next_state = ST_RUN;
      ST_RUN:
        if (!status_in.servo_on)
          next_state = ST_STOPPING;
      ST_STOPPING:
        if (status_in.servo_on)
          next_state = ST_RUN;
        else if (dly_done)
          next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
  end

  // stop requests from undervoltage or a warning with stop option
  logic uv_latched;
  logic next_uv_latched;
  logic alarm_shown;
  logic next_alarm_shown;
  logic stop_req;
  logic warn_stop;

  assign warn_stop = alarm_opt[FLD_Y] && status_in.overload_warn;

  always_comb
  begin
    next_uv_latched = uv_latched;
    if (status_in.undervoltage)
      next_uv_latched = 1'b1;
    else if (stop_opt[FLD_X] || status_in.alarm_clear)
      next_uv_latched = 1'b0;
    // alarm screen persists after clear unless the return option is set
    next_alarm_shown = alarm_shown;
    if (status_in.undervoltage)
      next_alarm_shown = 1'b1;
    else if (status_in.alarm_clear && alarm_opt[FLD_Z])
      next_alarm_shown = 1'b0;
  end

  assign stop_req = uv_latched || status_in.undervoltage || warn_stop;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      son_q       <= 1'b0;
      state       <= ST_OFF;
      uv_latched  <= 1'b0;
      alarm_shown <= 1'b0;
    end
    else
    begin
      son_q       <= status_in.servo_on;
      state       <= next_state;
      uv_latched  <= next_uv_latched;
      alarm_shown <= next_alarm_shown;
    end
  end

  // registered outputs
  logic [15:0] cmd_mag;
  logic [15:0] spd_mag;
  assign cmd_mag = speed_cmd_mv_in[CMD_W-1] ? 16'(-speed_cmd_mv_in) : 16'(speed_cmd_mv_in);
  assign spd_mag = motor_speed_in[SPEED_W-1] ? 16'(-motor_speed_in) : 16'(motor_speed_in);

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      speed_cmd_eff_out     <= '0;
      brake_interlock_out   <= 1'b0;
      servo_enable_out      <= 1'b0;
      zero_speed_output_out <= 1'b0;
      undervolt_alarm_out   <= 1'b0;
      stop_instant_out      <= 1'b0;
      stop_decel_out        <= 1'b0;
      history_clear_out     <= 1'b0;
      show_alarm_screen_out <= 1'b0;
      station_match_out     <= 1'b0;
      station_number_out    <= 6'h01;
      param_rd_data_out     <= 16'h0000;
    end
    else
    begin
      speed_cmd_eff_out <= (cmd_mag < dead_band) ? '0 : speed_cmd_mv_in;
      // negative delay drops the brake at once, positive holds it through the wait
      brake_interlock_out <= (next_state == ST_RUN) ||
                             (next_state == ST_STOPPING && !brake_neg);
      servo_enable_out <= (next_state == ST_RUN && !stop_req) ||
                          (next_state == ST_STOPPING && brake_neg);
      zero_speed_output_out <= (spd_mag < zero_window);
      undervolt_alarm_out   <= status_in.undervoltage || uv_latched;
      stop_instant_out <= (status_in.speed_mode && stop_opt[FLD_Y] && stop_req) ||
                          warn_stop;
      stop_decel_out <= status_in.speed_mode && !stop_opt[FLD_Y] && stop_req &&
                        !warn_stop;
      history_clear_out     <= power_up_in && alarm_opt[FLD_X];
      show_alarm_screen_out <= next_alarm_shown;
      station_match_out     <= (16'(link_station_in) == station);
      station_number_out    <= station[5:0];
      unique case (param_rd_addr_in)
        IDX_DEAD_BAND:  param_rd_data_out <= dead_band;
        IDX_BRAKE_DLY:  param_rd_data_out <= brake_dly;
        IDX_ZERO_SPEED: param_rd_data_out <= zero_window;
        IDX_STOP_OPT:   param_rd_data_out <= stop_opt;
        IDX_ALARM_OPT:  param_rd_data_out <= alarm_opt;
        IDX_STATION:    param_rd_data_out <= station;
        default:        param_rd_data_out <= 16'h0000;
      endcase
    end
  end
endmodule

/* inc/servo_seq_pkg.sv */
package servo_seq_pkg;
  // parameter indices (register port address)
  localparam logic [2:0] IDX_DEAD_BAND  = 3'h0;
  localparam logic [2:0] IDX_BRAKE_DLY  = 3'h1;
  localparam logic [2:0] IDX_ZERO_SPEED = 3'h2;
  localparam logic [2:0] IDX_STOP_OPT   = 3'h3;
  localparam logic [2:0] IDX_ALARM_OPT  = 3'h4;
  localparam logic [2:0] IDX_STATION    = 3'h5;
  localparam logic [2:0] IDX_RESERVED   = 3'h6;
  // reset values
  localparam logic [15:0] RST_DEAD_BAND  = 16'h000a;
  localparam logic [15:0] RST_BRAKE_DLY  = 16'h0064;
  localparam logic [15:0] RST_ZERO_SPEED = 16'h0032;
  localparam logic [15:0] RST_STOP_OPT   = 16'h0010;
  localparam logic [15:0] RST_ALARM_OPT  = 16'h0000;
  localparam logic [15:0] RST_STATION    = 16'h0001;
  // ranges
  localparam logic [15:0] MAX_DEAD_BAND  = 16'h03e8;
  localparam logic [15:0] MAX_BRAKE_MAG  = 16'h03e8;
  localparam logic [15:0] MAX_ZERO_SPEED = 16'h2710;
  localparam logic [15:0] MIN_STATION    = 16'h0001;
  localparam logic [15:0] MAX_STATION    = 16'h0020;
  // field positions (one hex digit each)
  localparam int FLD_X = 0;
  localparam int FLD_Y = 4;
  localparam int FLD_Z = 8;
  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_PERIOD_US;

  typedef struct packed {
    logic        wr;
    logic [2:0]  addr;
    logic [15:0] data;
  } param_wr_t;

  typedef struct packed {
    logic servo_on;
    logic undervoltage;
    logic overload_warn;
    logic alarm_clear;
    logic speed_mode;
  } drive_status_t;

  typedef enum logic [1:0] {
    ST_OFF      = 2'b00,
    ST_RUN      = 2'b01,
    ST_STOPPING = 2'b11
  } seq_state_t;
endpackage

/* testbench/host_link.sv */
module host_link
  import servo_seq_pkg::*;
(
  input  wire logic        ref_clk_in,
  output param_wr_t        param_wr_out,
  output logic [2:0]       rd_addr_out,
  input  wire logic [15:0] rd_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial param_wr_out = '0;
  initial rd_addr_out = 3'h7;
  // single drive on this link, so its station is unique; writes are few, no wear limit needed
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge ref_clk_in);
    param_wr_out = '{wr: 1'b1, addr: a, data: d};
    @(negedge ref_clk_in);
    // released fields show garbage, never the last value
    param_wr_out = '{wr: 1'b0, addr: ~a, data: ~d};
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge ref_clk_in);
    rd_addr_out = a;
    @(negedge ref_clk_in);
    d = rd_data_in;
  endtask
endmodule

/* testbench/servo_seq_props.sv */
module servo_seq_props #(
  parameter int CMD_W   = 16,
  parameter int SPEED_W = 16
) (
  input wire logic                          ref_clk_in,
  input wire logic                          sys_rst_in,
  input wire servo_seq_pkg::param_wr_t      param_wr_in,
  input wire logic [2:0]                    param_rd_addr_in,
  input wire logic [15:0]                   param_rd_data_out,
  input wire servo_seq_pkg::drive_status_t  status_in,
  input wire logic signed [CMD_W-1:0]       speed_cmd_mv_in,
  input wire logic signed [SPEED_W-1:0]     motor_speed_in,
  input wire logic signed [CMD_W-1:0]       speed_cmd_eff_out,
  input wire logic                          zero_speed_output_out,
  input wire logic                          undervolt_alarm_out,
  input wire logic                          history_clear_out,
  input wire logic [5:0]                    station_number_out,
  input wire logic                          brake_interlock_out,
  input wire logic                          servo_enable_out,
  input wire logic                          stop_instant_out,
  input wire logic                          stop_decel_out,
  input wire logic                          show_alarm_screen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // beyond the widest legal dead band the command must pass untouched
  eff_pass_a: assert property ((speed_cmd_mv_in > 1000 || speed_cmd_mv_in < -1000) |=>
    speed_cmd_eff_out == $past(speed_cmd_mv_in)) else $error("wide command was altered");
  eff_form_a: assert property (speed_cmd_eff_out == '0 ||
    speed_cmd_eff_out == $past(speed_cmd_mv_in)) else $error("command neither zero nor passed");
  eff_zero_a: assert property (speed_cmd_mv_in == '0 |=> speed_cmd_eff_out == '0)
    else $error("zero command not zero");
  zsp_fast_a: assert property ((motor_speed_in > 10000 || motor_speed_in < -10000) |=>
    !zero_speed_output_out) else $error("zero speed flag at high speed");
  uv_alarm_a: assert property (status_in.undervoltage |=> undervolt_alarm_out)
    else $error("undervoltage alarm missing");
  hist_pulse_a: assert property (history_clear_out |=> !history_clear_out)
    else $error("history clear longer than one cycle");
  stn_range_a: assert property (station_number_out >= 6'h01 && station_number_out <= 6'h20)
    else $error("station number out of range");
  stn_hold_a: assert property ($changed(station_number_out) |->
    $past(param_wr_in.wr) || $past(param_wr_in.wr, 2)) else $error("station moved without write");
  rsvd_read_a: assert property (param_rd_addr_in == 3'h6 |=> param_rd_data_out == 16'h0000)
    else $error("reserved index read nonzero");
  brake_part_a: assert property (!status_in.servo_on |=>
    !(servo_enable_out && brake_interlock_out)) else $error("servo and brake both on after off");
  stop_mode_a: assert property (status_in.speed_mode && status_in.undervoltage |=>
    stop_instant_out || stop_decel_out) else $error("no stop on undervoltage");
  scr_set_a: assert property (status_in.undervoltage |=> show_alarm_screen_out)
    else $error("alarm screen not shown");
endmodule

bind servo_sequence servo_seq_props #(.CMD_W(CMD_W), .SPEED_W(SPEED_W)) props (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .param_wr_in(param_wr_in),
  .param_rd_addr_in(param_rd_addr_in), .param_rd_data_out(param_rd_data_out),
  .status_in(status_in), .speed_cmd_mv_in(speed_cmd_mv_in), .motor_speed_in(motor_speed_in),
  .speed_cmd_eff_out(speed_cmd_eff_out), .zero_speed_output_out(zero_speed_output_out),
  .undervolt_alarm_out(undervolt_alarm_out), .history_clear_out(history_clear_out),
  .station_number_out(station_number_out), .brake_interlock_out(brake_interlock_out),
  .servo_enable_out(servo_enable_out), .stop_instant_out(stop_instant_out),
  .stop_decel_out(stop_decel_out), .show_alarm_screen_out(show_alarm_screen_out));

/* testbench/tb_servo_sequence_and_option_params.sv */
module tb_servo_sequence_and_option_params
  import servo_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  param_wr_t          pw;
  logic [2:0]         ra;
  logic [15:0]        rdd;
  drive_status_t      st = '0;
  logic signed [15:0] cmd = '0;
  logic signed [15:0] spd = '0;
  logic               pup = 1'b0;
  logic [7:0]         lst = '0;
  logic signed [15:0] eff;
  logic               brk, sen, zero_speed_output, uva, sti, sdc, hcl, sca, smt;
  logic [5:0]         stn;
  int                 bad_count = 0;
  int                 cmp_count = 0;
  always #12.5 clk = ~clk;

  servo_sequence uut (.ref_clk_in(clk), .sys_rst_in(rst), .param_wr_in(pw),
    .param_rd_addr_in(ra), .param_rd_data_out(rdd), .status_in(st), .speed_cmd_mv_in(cmd),
    .motor_speed_in(spd), .power_up_in(pup), .link_station_in(lst), .speed_cmd_eff_out(eff),
    .brake_interlock_out(brk), .servo_enable_out(sen), .zero_speed_output_out(zero_speed_output),
    .undervolt_alarm_out(uva), .stop_instant_out(sti), .stop_decel_out(sdc),
    .history_clear_out(hcl), .show_alarm_screen_out(sca), .station_match_out(smt),
    .station_number_out(stn));
  host_link host (.ref_clk_in(clk), .param_wr_out(pw), .rd_addr_out(ra), .rd_data_in(rdd));

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_regs();
    logic [15:0] dflt [7];
    logic [15:0] v;
    dflt = '{16'h000a, 16'h0064, 16'h0032, 16'h0010, 16'h0000, 16'h0001, 16'h0000};
    host.wr(IDX_RESERVED, 16'hffff);
    host.wr(IDX_DEAD_BAND, 16'h03e9);
    for (int i = 0; i < 7; i++)
    begin
      host.rd(3'(i), v);
      chk("param", v, dflt[i]);
    end
  endtask
  task automatic t_cmd();
    logic signed [15:0] c [4];
    c = '{16'sd9, 16'sd10, -16'sd9, -16'sd10};
    for (int i = 0; i < 4; i++)
    begin
      cmd = c[i];
      spd = c[i] * 16'sd5;
      cyc(2);
      chk("eff", eff, i[0] ? c[i] : 16'h0000);
      chk("zsp", 16'(zero_speed_output), {15'h0000, ~i[0]});
    end
    host.wr(IDX_DEAD_BAND, 16'h03e8);
    cmd = 16'sd999;
    cyc(2);
    chk("eff", eff, 16'h0000);
  endtask
  task automatic t_stn();
    host.wr(IDX_STATION, 16'h0020);
    host.wr(IDX_STATION, 16'h0021);
    host.wr(IDX_STATION, 16'h0000);
    lst = 8'h20;
    cyc(2);
    chk("station", 16'(stn), 16'h0020);
    chk("match", 16'(smt), 16'h0001);
    lst = 8'h1f;
    cyc(2);
    chk("match", 16'(smt), 16'h0000);
  endtask
  task automatic t_brake();
    st.servo_on = 1'b1;
    host.wr(IDX_BRAKE_DLY, 16'h0000);
    cyc(3);
    chk("brake", 16'(brk), 16'h0001);
    st.servo_on = 1'b0;
    cyc(3);
    chk("brake", 16'(brk), 16'h0000);
    // one ms delay: servo drops at once, brake holds until the next tick
    st.servo_on = 1'b1;
    host.wr(IDX_BRAKE_DLY, 16'h0001);
    cyc(3);
    st.servo_on = 1'b0;
    cyc(3);
    chk("brake", 16'(brk), 16'h0001);
    chk("enable", 16'(sen), 16'h0000);
    for (int n = 0; n < 40010 && brk !== 1'b0; n++)
      cyc(1);
    chk("brake", 16'(brk), 16'h0000);
    st.servo_on = 1'b1;
    host.wr(IDX_BRAKE_DLY, 16'hffff);
    cyc(3);
    st.servo_on = 1'b0;
    cyc(3);
    chk("brake", 16'(brk), 16'h0000);
    chk("enable", 16'(sen), 16'h0001);
    // one ms is one tick of 40000 cycles, plus a little pipeline slack
    for (int n = 0; n < 40010 && sen !== 1'b0; n++)
      cyc(1);
    chk("enable", 16'(sen), 16'h0000);
  endtask
  task automatic t_opts();
    logic [15:0] v;
    st = '{servo_on: 1'b1, speed_mode: 1'b1, default: 1'b0};
    host.wr(IDX_STOP_OPT, 16'h0011);
    st.undervoltage = 1'b1;
    cyc(2);
    chk("uv", 16'(uva), 16'h0001);
    chk("instant", 16'(sti), 16'h0001);
    chk("enable", 16'(sen), 16'h0000);
    st.undervoltage = 1'b0;
    cyc(2);
    chk("uv", 16'(uva), 16'h0000);
    chk("enable", 16'(sen), 16'h0001);
    host.wr(IDX_STOP_OPT, 16'h0000);
    st.undervoltage = 1'b1;
    cyc(2);
    chk("decel", 16'(sdc), 16'h0001);
    st.undervoltage = 1'b0;
    cyc(2);
    chk("uv", 16'(uva), 16'h0001);
    st.alarm_clear = 1'b1;
    cyc(1);
    st.alarm_clear = 1'b0;
    cyc(2);
    chk("uv", 16'(uva), 16'h0000);
    chk("screen", 16'(sca), 16'h0001);
    st.overload_warn = 1'b1;
    cyc(2);
    chk("instant", 16'(sti), 16'h0000);
    host.wr(IDX_ALARM_OPT, 16'h0010);
    cyc(2);
    chk("instant", 16'(sti), 16'h0001);
    st.overload_warn = 1'b0;
    host.wr(IDX_ALARM_OPT, 16'h0011);
    pup = 1'b1;
    cyc(1);
    pup = 1'b0;
    chk("hclr", 16'(hcl), 16'h0001);
    host.rd(IDX_ALARM_OPT, v);
    chk("alarm_opt", v, 16'h0010);
    host.wr(IDX_ALARM_OPT, 16'h0100);
    st.undervoltage = 1'b1;
    cyc(1);
    chk("screen", 16'(sca), 16'h0001);
    st.undervoltage = 1'b0;
    st.alarm_clear = 1'b1;
    cyc(1);
    st.alarm_clear = 1'b0;
    chk("screen", 16'(sca), 16'h0000);
  endtask

  initial
  begin
    cyc(4);
    rst = 1'b0;
    chk("station", 16'(stn), 16'h0001);
    t_regs();
    t_cmd();
    t_stn();
    t_brake();
    t_opts();
    close_out();
  end
  initial
  begin
    #2_300_000;
    bad_count++;
    close_out();
  end
endmodule
